// ==== crih_regs.svh ====
`ifndef CRIH_REGS_SVH
`define CRIH_REGS_SVH

// Words of configuration memory cleared during initialisation.
`define CRIH_CLEAR_WORDS 16'h0100
`define CRIH_ADDR_W 16
// Reset value of the two-stage synchronisers (pins idle high).
`define CRIH_SYNC_RST 2'h3

`endif

// ==== crih_pkg.sv ====
package crih_pkg;

    typedef enum logic [2:0]
    {
        CRIH_POWERUP,
        CRIH_CLEAR,
        CRIH_HOLD_RESET,
        CRIH_WAIT_INIT,
        CRIH_CONFIG,
        CRIH_ERROR,
        CRIH_DONE
    } crih_state_t;

endpackage

// ==== crih_sync.sv ====
`timescale 1ns/1ns
`include "crih_regs.svh"

// Two-flop synchroniser for a pin that idles high.
module crih_sync
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin_in,
    output logic pin_sync
);

    logic [1:0] sync_r;
    logic [1:0] sync_nxt;

    always_comb
    begin
        sync_nxt = {sync_r[0], pin_in};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_r <= `CRIH_SYNC_RST;
        end
        else
        begin
            sync_r <= sync_nxt;
        end
    end

    assign pin_sync = sync_r[1];

endmodule

// ==== crih_ctrl.sv ====
`timescale 1ns/1ns
`include "crih_regs.svh"

// What this block does
// - Reset input low resets configuration logic and clears whole memory, then reconfigures.
// - Reset begins on falling edge; new configuration begins on following rising edge.
// - A reset input already low at power-up is not taken as a reset.
// - Initialisation line is pulled low while memory clears, released when done.
// - After initialisation, configuration starts only once the line samples high.
// - During configuration the line is driven low to report an error.
module crih_ctrl
#(
    parameter int ADDR_W = `CRIH_ADDR_W,
    parameter logic [ADDR_W-1:0] CLEAR_WORDS = `CRIH_CLEAR_WORDS
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cfg_reset_n,
    input wire logic init_flag_n_in,
    output logic init_flag_n_out,
    output logic init_flag_n_oe,
    input wire logic cfg_error,
    input wire logic cfg_finished,
    output logic mem_clear_en,
    output logic [ADDR_W-1:0] mem_clear_addr,
    output logic cfg_start,
    output logic cfg_active,
    output logic cfg_logic_reset
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rst_s;
    logic init_s;

    crih_sync u_rst_sync
    (
        .clk(clk),
        .resetn(resetn),
        .pin_in(cfg_reset_n),
        .pin_sync(rst_s)
    );

    crih_sync u_init_sync
    (
        .clk(clk),
        .resetn(resetn),
        .pin_in(init_flag_n_in),
        .pin_sync(init_s)
    );

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    crih_pkg::crih_state_t state_r;
    crih_pkg::crih_state_t state_nxt;
    logic rst_prev_r;
    logic rst_prev_nxt;
    logic [ADDR_W-1:0] addr_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic drive_r;
    logic drive_nxt;
    logic clr_r;
    logic clr_nxt;
    logic start_r;
    logic start_nxt;
    logic active_r;
    logic active_nxt;
    logic lrst_r;
    logic lrst_nxt;
    logic fall;
    logic rise;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic armed_r;
    logic armed_nxt;

    // arm after true high
    // The reset pin arms only once the synchroniser has flushed and shown a real high.
    // A pin already low at power-up therefore never counts as a falling edge.
    assign fall = armed_r && rst_prev_r && !rst_s;
    assign rise = !rst_prev_r && rst_s;

    always_comb
    begin
        state_nxt = state_r;
        rst_prev_nxt = rst_s;
        settle_nxt = {settle_r[0], 1'b1};
        armed_nxt = armed_r || (settle_r[1] && rst_s);
        addr_nxt = addr_r;
        start_nxt = 1'b0;
        case (state_r)
            crih_pkg::CRIH_POWERUP:
            begin
                addr_nxt = '0;
                state_nxt = crih_pkg::CRIH_CLEAR;
            end
            crih_pkg::CRIH_CLEAR:
            begin
                if (fall)
                begin
                    addr_nxt = '0;
                    state_nxt = crih_pkg::CRIH_HOLD_RESET;
                end
                else if (addr_r == CLEAR_WORDS - 1'b1)
                begin
                    state_nxt = crih_pkg::CRIH_WAIT_INIT;
                end
                else
                begin
                    addr_nxt = addr_r + 1'b1;
                end
            end
            crih_pkg::CRIH_HOLD_RESET:
            begin
                addr_nxt = '0;
                if (rise)
                begin
                    state_nxt = crih_pkg::CRIH_CLEAR;
                end
            end
            // wait for a high on the line
            crih_pkg::CRIH_WAIT_INIT:
            begin
                if (fall)
                begin
                    state_nxt = crih_pkg::CRIH_HOLD_RESET;
                end
                else if (init_s)
                begin
                    start_nxt = 1'b1;
                    state_nxt = crih_pkg::CRIH_CONFIG;
                end
            end
            crih_pkg::CRIH_CONFIG:
            begin
                if (fall)
                begin
                    state_nxt = crih_pkg::CRIH_HOLD_RESET;
                end
                else if (cfg_error)
                begin
                    state_nxt = crih_pkg::CRIH_ERROR;
                end
                else if (cfg_finished)
                begin
                    state_nxt = crih_pkg::CRIH_DONE;
                end
            end
            crih_pkg::CRIH_ERROR, crih_pkg::CRIH_DONE:
            begin
                if (fall)
                begin
                    state_nxt = crih_pkg::CRIH_HOLD_RESET;
                end
            end
            default:
            begin
                state_nxt = crih_pkg::CRIH_POWERUP;
            end
        endcase
        // line low while powering up, clearing, held in reset or reporting an error
        drive_nxt = (state_nxt == crih_pkg::CRIH_CLEAR) || (state_nxt == crih_pkg::CRIH_HOLD_RESET)
                    || (state_nxt == crih_pkg::CRIH_POWERUP)
                    || (state_nxt == crih_pkg::CRIH_ERROR);
        clr_nxt = (state_nxt == crih_pkg::CRIH_CLEAR);
        active_nxt = (state_nxt == crih_pkg::CRIH_CONFIG);
        lrst_nxt = (state_nxt == crih_pkg::CRIH_HOLD_RESET);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= crih_pkg::CRIH_POWERUP;
            rst_prev_r <= 1'b1;
            settle_r <= 2'h0;
            armed_r <= 1'b0;
            addr_r <= '0;
            drive_r <= 1'b1;
            clr_r <= 1'b0;
            start_r <= 1'b0;
            active_r <= 1'b0;
            lrst_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            rst_prev_r <= rst_prev_nxt;
            settle_r <= settle_nxt;
            armed_r <= armed_nxt;
            addr_r <= addr_nxt;
            drive_r <= drive_nxt;
            clr_r <= clr_nxt;
            start_r <= start_nxt;
            active_r <= active_nxt;
            lrst_r <= lrst_nxt;
        end
    end

    assign init_flag_n_out = 1'b0;
    assign init_flag_n_oe = drive_r;
    assign mem_clear_en = clr_r;
    assign mem_clear_addr = addr_r;
    assign cfg_start = start_r;
    assign cfg_active = active_r;
    assign cfg_logic_reset = lrst_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence fall_seq;
        armed_r && rst_prev_r && !rst_s;
    endsequence

    property p_fall_reset;
        @(posedge clk) disable iff (!resetn)
        fall_seq and (state_r != crih_pkg::CRIH_POWERUP) |=> cfg_logic_reset && init_flag_n_oe;
    endproperty

    fall_reset_a: assert property (p_fall_reset) else $error("reset edge not taken");

    hold_until_rise_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_logic_reset && !rise |=> cfg_logic_reset)
        else $error("logic reset released before rising edge");

    rise_clears_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == crih_pkg::CRIH_HOLD_RESET && rise |=> mem_clear_en && mem_clear_addr == '0)
        else $error("clear not restarted");

    powerup_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        state_r == crih_pkg::CRIH_POWERUP |=> mem_clear_en && !cfg_logic_reset)
        else $error("power-up did not clear");

    clear_drives_a: assert property (@(posedge clk) disable iff (!resetn)
        mem_clear_en |-> init_flag_n_oe && !init_flag_n_out)
        else $error("line released while clearing");

    start_needs_high_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_start |-> $past(init_s) && !init_flag_n_oe && cfg_active)
        else $error("start without high line");

    error_drives_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_active && cfg_error && !fall |=> ##1 init_flag_n_oe)
        else $error("error not reported");

    config_released_a: assert property (@(posedge clk) disable iff (!resetn)
        cfg_active |-> !init_flag_n_oe)
        else $error("line driven during good configuration");

endmodule

// ==== crih_host.sv ====
`timescale 1ns/1ns

// ----------------------------------------
// Board host on the reset and init lines
// ----------------------------------------
module crih_host
(
    input wire logic rst_req,
    input wire logic hold_init,
    input wire logic dev_oe,
    input wire logic dev_out,
    output logic cfg_reset_n,
    output logic init_line
);
    // The reset line is pulled up and is low only while the host asserts it.
    assign cfg_reset_n = !rst_req;
    // host postpones configuration
    // The open-drain line is pulled up and is low while either party pulls it.
    assign init_line = !((dev_oe && !dev_out) || hold_init);
endmodule

// ==== crih_ctrl_tb.sv ====
`timescale 1ns/1ns

module crih_ctrl_tb;
    localparam int NW = 4;
    logic clk, resetn, rst_req, hold_init, cfg_error, cfg_finished, err;
    logic cfg_reset_n, init_line, oe, dout, clr_en, start, active, lreset;
    logic [15:0] addr;
    int fails = 0, checks_done = 0, cyc = 0, k, n;

    crih_ctrl #(.ADDR_W(16), .CLEAR_WORDS(16'h0004)) i_crih_ctrl
    (
        .clk(clk), .resetn(resetn), .cfg_reset_n(cfg_reset_n), .init_flag_n_in(init_line),
        .init_flag_n_out(dout), .init_flag_n_oe(oe), .cfg_error(cfg_error),
        .cfg_finished(cfg_finished), .mem_clear_en(clr_en), .mem_clear_addr(addr),
        .cfg_start(start), .cfg_active(active), .cfg_logic_reset(lreset)
    );

    crih_host i_crih_host
    (
        .rst_req(rst_req), .hold_init(hold_init), .dev_oe(oe), .dev_out(dout),
        .cfg_reset_n(cfg_reset_n), .init_line(init_line)
    );

    // ----------------
    // Shared tasks
    // ----------------
    // A reported error pulls the line low; a clean finish leaves it released high.
    function automatic logic [15:0] line_exp(input logic error_seen);
        return error_seen ? 16'h0000 : 16'h0001;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits at falling edges for clear, start or logic reset to show high.
    task automatic wait_for(input int sel, input int lim);
        int i;
        i = 0;
        while (i < lim && (sel == 0 ? clr_en : sel == 1 ? start : lreset) !== 1'b1)
        begin
            @(negedge clk);
            i++;
        end
        check("wait_bound", 16'(i < lim), 16'h0001);
    endtask

    task automatic clear_run;
        int i;
        wait_for(0, 8);
        i = 0;
        while (clr_en === 1'b1 && i < 64)
        begin
            check("clear_addr", addr, i[15:0]);
            check("init_low", 16'(init_line), 16'h0000);
            check("init_drive", 16'({oe, dout}), 16'h0002);
            @(negedge clk);
            i++;
        end
        check("clear_len", i[15:0], NW[15:0]);
        check("init_release", 16'(oe), 16'h0000);
    endtask

    // ----------------
    // Clock and timeout
    // ----------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    // ----------------
    // Main sequence
    // ----------------
    initial
    begin
        {resetn, rst_req, cfg_error, cfg_finished} = '0;
        hold_init = 1'b1;
        k = $urandom(32'hda06);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        clear_run();
        for (k = 0; k < 4; k++)
        begin
            n = 3 + $urandom_range(0, 12);
            @(posedge clk);
            hold_init <= 1'b1;
            cfg_error <= 1'($urandom_range(0, 1));
            repeat (n)
            begin
                @(negedge clk);
                check("early_start", 16'(start | active), 16'h0000);
            end
            @(posedge clk);
            hold_init <= 1'b0;
            cfg_error <= 1'b0;
            @(negedge clk);
            wait_for(1, 8);
            check("active_on", 16'(active), 16'h0001);
            @(negedge clk);
            check("start_pulse", 16'(start), 16'h0000);
            err = k[0];
            @(posedge clk);
            cfg_error <= err;
            cfg_finished <= !err;
            @(posedge clk);
            cfg_error <= 1'b0;
            cfg_finished <= 1'b0;
            @(negedge clk);
            check("active_off", 16'(active), 16'h0000);
            check("error_flag", 16'(init_line), line_exp(err));
            @(posedge clk);
            rst_req <= 1'b1;
            hold_init <= 1'b1;
            @(negedge clk);
            wait_for(2, 6);
            check("reset_oe", 16'(oe), 16'h0001);
            repeat (n)
            begin
                @(negedge clk);
                check("held_reset", 16'({lreset, clr_en}), 16'h0002);
            end
            @(posedge clk);
            rst_req <= 1'b0;
            @(negedge clk);
            clear_run();
            check("reset_end", 16'(lreset), 16'h0000);
        end
        @(posedge clk);
        resetn <= 1'b0;
        rst_req <= 1'b1;
        @(posedge clk);
        resetn <= 1'b1;
        repeat (8)
        begin
            @(negedge clk);
            check("powerup_low", 16'(lreset), 16'h0000);
        end
        tally_and_finish();
    end
endmodule
